/* File: design/irq_ctrl.sv */
// interrupt controller of a small microcontroller core, registers over apb
// Operation
// - global enable bit 7 passes unmasked requests; clear blocks all
// - global enable clears on every reset
// - each source has its own enable bit
// - return-from-interrupt sets global enable again
// - taking interrupt clears global enable, stacks return address, vectors 0004h
// - external event to vector latency three or four instruction cycles
// - flags set by events regardless of any enable
// - clearing global enable defers pending requests until it is set again
// - external pin edge: rising when option bit 6 set, else falling
// - valid edge sets flag bit 1, gated by enable bit 4
// - external pin wakes from sleep if enabled; global enable decides vectoring
// - timer rollover sets flag bit 2, gated by enable bit 5
// - selected port pin change sets flag bit 0, gated by bit 3
// - change coinciding with Q2 port read may be lost
// - peripheral flags bits 7..0 with enables in same positions, bit 1 unused
// - external flag set during Q4-Q1, sampled once per cycle at Q1; here it is set on whichever sub-cycle the edge is seen
// - only return pc is stacked; software saves other context
// - enabled flag during sleep wakes regardless of global enable
// - enabled pending flag wakes immediately after sleep instruction completes
`include "irq_ctrl_defines.svh"
`default_nettype none
module irq_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources
  input wire logic external_irq_pin,
  input wire logic [5:0] port_pins,
  input wire logic timer0_rollover,
  input wire logic [7:0] periph_events,
  // core sequencer
  input wire logic sleep_instr,
  input wire logic return_from_irq_instr,
  input wire logic global_clear_instr,
  input wire logic [12:0] return_pc,
  output logic irq_take,
  output logic [12:0] vector_pc,
  output logic push_stack,
  output logic [12:0] stack_data,
  output logic dummy_cycle,
  output logic wake_up,
  output logic in_sleep
);
  phase_if ph ();
  phase_gen u_phase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ph(ph.gen)
  );

  logic [7:0] irq_control_main_q;
  logic [7:0] peripheral_irq_flags_q;
  logic [7:0] peripheral_irq_enables_q;
  logic [7:0] option_q;
  logic [5:0] per_pin_change_select_q;
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic [5:0] port_s1_q, port_s2_q, port_latch_q;
  logic ext_flag_sampled_q;
  logic [1:0] dummy_cnt_q;
  irq_ctrl_pkg::core_state_t state_q;

  // pins pass two flops before any logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      port_s1_q <= 6'h00;
      port_s2_q <= 6'h00;
    end else begin
      ext_s1_q <= external_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      port_s1_q <= port_pins;
      port_s2_q <= port_s1_q;
    end
  end

  // edge and change detection
  wire edge_sel = option_q[`BIT_EDGE_SELECT];
  wire ext_edge = edge_sel ? (ext_s2_q & ~ext_prev_q) : (~ext_s2_q & ext_prev_q);
  // port compares against value latched by the q2 read; a change in that cycle is missed
  wire [5:0] port_diff = (port_s2_q ^ port_latch_q) & per_pin_change_select_q;
  wire port_change = (|port_diff) && !ph.q2_en;

  // apb decode; index = byte address / 4
  wire [9:0] reg_idx = paddr[11:2];
  wire acc = psel && penable;
  // a write lands only at the edge where the master sees pready, so a flag
  // set in the wait state is not overwritten by a second copy of the write
  wire wr = acc && pwrite && pready;
  wire hit_main = reg_idx == 10'(`IDX_CONTROL_MAIN);
  wire hit_pflag = reg_idx == 10'(`IDX_PERIPH_FLAGS);
  wire hit_pen = reg_idx == 10'(`IDX_PERIPH_ENABLES);
  wire hit_opt = reg_idx == 10'(`IDX_OPTION);
  wire hit_sel = reg_idx == 10'(`IDX_CHANGE_SELECT);
  wire hit_stat = reg_idx == 10'(`IDX_CORE_STATUS);
  wire mapped = hit_main | hit_pflag | hit_pen | hit_opt | hit_sel | hit_stat;
  wire [7:0] wbyte = pwdata[7:0];

  // request gating
  wire [7:0] periph_pending = peripheral_irq_flags_q & peripheral_irq_enables_q
                              & `PERIPH_IMPL_MASK;
  wire periph_req = irq_control_main_q[`BIT_PERIPH_EN] && (|periph_pending);
  wire timer_req = irq_control_main_q[`BIT_TIMER0_EN]
                   && irq_control_main_q[`BIT_TIMER0_FLAG];
  wire change_req = irq_control_main_q[`BIT_CHANGE_EN]
                    && irq_control_main_q[`BIT_CHANGE_FLAG];
  // the flag is looked at through take, which fires at q1, and the wake and sleep checks; a stale sampled
  // copy would vector on a flag that software has already cleared
  wire ext_req = irq_control_main_q[`BIT_EXT_EN]
                 && irq_control_main_q[`BIT_EXT_FLAG];
  wire any_enabled = periph_req | timer_req | change_req | ext_req;
  wire global_en = irq_control_main_q[`BIT_GLOBAL_EN];
  // taken at q1 only; a clearing instruction in the same cycle defers it
  wire take = ph.q1_en && (state_q == irq_ctrl_pkg::run) && global_en && any_enabled
              && !global_clear_instr;
  wire wake = (state_q == irq_ctrl_pkg::sleeping) && any_enabled;

  // main control: hardware set wins over software clear
  wire [7:0] hw_set_main = {5'h00, timer0_rollover, ext_edge, port_change};
  logic [7:0] main_d;
  always_comb begin
    main_d = irq_control_main_q;
    if (wr && hit_main) main_d = wbyte;
    main_d = main_d | hw_set_main;
    if (take || global_clear_instr) main_d[`BIT_GLOBAL_EN] = 1'b0;
    if (return_from_irq_instr) main_d[`BIT_GLOBAL_EN] = 1'b1;
  end
  wire [7:0] pflag_d = (((wr && hit_pflag) ? wbyte : peripheral_irq_flags_q) | periph_events)
                       & `PERIPH_IMPL_MASK;

  // register file
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_control_main_q <= `RESET_BYTE;
      peripheral_irq_flags_q <= `RESET_BYTE;
      peripheral_irq_enables_q <= `RESET_BYTE;
      option_q <= `OPTION_RESET;
      per_pin_change_select_q <= 6'h00;
    end else begin
      irq_control_main_q <= main_d;
      peripheral_irq_flags_q <= pflag_d;
      if (wr && hit_pen) peripheral_irq_enables_q <= wbyte & `PERIPH_IMPL_MASK;
      if (wr && hit_opt) option_q <= wbyte;
      if (wr && hit_sel) per_pin_change_select_q <= wbyte[5:0];
    end
  end

  // port read latch at q2, external flag sampled at q1
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_latch_q <= 6'h00;
      ext_flag_sampled_q <= 1'b0;
    end else begin
      if (ph.q2_en) port_latch_q <= port_s2_q;
      if (ph.q1_en) ext_flag_sampled_q <= irq_control_main_q[`BIT_EXT_FLAG];
    end
  end

  // core sequencer handshake
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= irq_ctrl_pkg::run;
      dummy_cnt_q <= 2'h0;
      irq_take <= 1'b0;
      push_stack <= 1'b0;
      stack_data <= 13'h0000;
      vector_pc <= 13'h0000;
      dummy_cycle <= 1'b0;
      wake_up <= 1'b0;
      in_sleep <= 1'b0;
    end else begin
      irq_take <= take;
      push_stack <= take;
      wake_up <= 1'b0;
      if (take) begin
        stack_data <= return_pc;
        vector_pc <= `VECTOR_ADDR;
      end
      case (state_q)
        irq_ctrl_pkg::run: begin
          // sleep instruction completes, then wakes at once if something is pending
          if (take) begin
            state_q <= irq_ctrl_pkg::dummy;
            dummy_cnt_q <= 2'h0;
            dummy_cycle <= 1'b1;
          end else if (sleep_instr && !any_enabled) begin
            state_q <= irq_ctrl_pkg::sleeping;
            in_sleep <= 1'b1;
          end else if (sleep_instr) begin
            wake_up <= 1'b1;
          end
        end
        irq_ctrl_pkg::sleeping: begin
          if (wake) begin
            state_q <= irq_ctrl_pkg::run;
            in_sleep <= 1'b0;
            wake_up <= 1'b1;
          end
        end
        irq_ctrl_pkg::dummy: begin
          // dummy cycles counted in instruction cycles
          if (ph.q1_en) begin
            if (dummy_cnt_q == `DUMMY_CYCLES - 2'h1) begin
              state_q <= irq_ctrl_pkg::run;
              dummy_cycle <= 1'b0;
            end
            dummy_cnt_q <= dummy_cnt_q + 2'h1;
          end
        end
        default: state_q <= irq_ctrl_pkg::run;
      endcase
    end
  end

  // apb read mux, one wait state; unmapped reads zero with error
  wire [7:0] rd_byte = hit_main ? irq_control_main_q :
                       hit_pflag ? peripheral_irq_flags_q :
                       hit_pen ? peripheral_irq_enables_q :
                       hit_opt ? option_q :
                       hit_sel ? {2'h0, per_pin_change_select_q} :
                       hit_stat ? {5'h00, dummy_cycle, in_sleep, ext_flag_sampled_q} : 8'h00;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // registered answer: one wait state, ready on the second access cycle
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= {24'h000000, rd_byte};
    end
  end

  // assertions
  sequence take_seq;
    take;
  endsequence
  global_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    take_seq |=> !irq_control_main_q[`BIT_GLOBAL_EN]) else $error("global enable kept");
  vector_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    take |=> (vector_pc == `VECTOR_ADDR) && push_stack) else $error("bad vector");
  gie_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !global_en |-> !take) else $error("taken while disabled");
  return_from_irq_instr_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    return_from_irq_instr |=> global_en) else $error("return did not enable");
  flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timer0_rollover |=> irq_control_main_q[`BIT_TIMER0_FLAG]) else $error("flag lost");
  periph_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !irq_control_main_q[`BIT_PERIPH_EN] |-> !periph_req) else $error("periph leak");
  dummy_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(dummy_cycle) |-> dummy_cycle [*5]) else $error("dummy too short");
  wake_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wake |=> wake_up && !in_sleep) else $error("no wake");
  ext_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_edge |=> irq_control_main_q[`BIT_EXT_FLAG]) else $error("edge flag lost");
  // apb answers after exactly one wait state
  apb_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready) else $error("no ready");
  // enables keep only implemented bits
  enable_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && hit_pen) |=> peripheral_irq_enables_q == ($past(wbyte) & `PERIPH_IMPL_MASK))
    else $error("enable write lost");
  // peripheral events set flags with every enable off as well
  pflag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    periph_events[7] |=> peripheral_irq_flags_q[7]) else $error("periph flag lost");
  unused_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !peripheral_irq_flags_q[1]) else $error("bit 1 set");
  // vectoring only at the q1 sample point
  take_q1_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    take |-> ph.q1_en) else $error("take off q1");
  // a clearing instruction defers the request
  clear_defer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    global_clear_instr |-> !take) else $error("taken during clear");
endmodule : irq_ctrl
`default_nettype wire

/* File: common/irq_ctrl_defines.svh */
// register offsets, bit positions, reset values and timing constants of the interrupt block
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH
// register indices; printed offsets are not all multiples of four, byte address is 4x
`define IDX_CONTROL_MAIN 8'h0b
`define IDX_PERIPH_FLAGS 8'h0c
`define IDX_PERIPH_ENABLES 8'h8c
`define IDX_OPTION 8'h81
`define IDX_CHANGE_SELECT 8'h96
`define IDX_CORE_STATUS 8'h90
// main control register bits
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_TIMER0_EN 5
`define BIT_EXT_EN 4
`define BIT_CHANGE_EN 3
`define BIT_TIMER0_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_CHANGE_FLAG 0
// option register edge select bit
`define BIT_EDGE_SELECT 6
// peripheral flag/enable implemented bits (bit 1 unimplemented)
`define PERIPH_IMPL_MASK 8'hfd
`define RESET_BYTE 8'h00
`define OPTION_RESET 8'hff
`define VECTOR_ADDR 13'h0004
// four sub-cycles per instruction cycle
`define QUARTER_NS 8
`define CLK_PERIOD_NS 8
`define QUARTER_CYCLES ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUMMY_CYCLES 2'h2
`endif

/* File: common/irq_ctrl_pkg.sv */
// types of the interrupt block
`default_nettype none
package irq_ctrl_pkg;
  typedef enum logic [1:0] {q1, q2, q3, q4} subcycle_t;
  typedef enum logic [1:0] {run, sleeping, dummy} core_state_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

/* File: common/phase_if.sv */
// sub-cycle phase strobes shared between phase generator and controller
`default_nettype none
interface phase_if;
  logic q1_en;
  logic q2_en;
  logic q4_en;
  modport gen (output q1_en, output q2_en, output q4_en);
  modport use_ (input q1_en, input q2_en, input q4_en);
endinterface : phase_if
`default_nettype wire

/* File: design/phase_gen.sv */
// four-phase sub-cycle enable generator
`include "irq_ctrl_defines.svh"
`default_nettype none
module phase_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // phase strobes
  phase_if.gen ph
);
  logic [7:0] div_q;
  irq_ctrl_pkg::subcycle_t q_q;
  wire step = (div_q == 8'(`QUARTER_CYCLES - 1));
  // quarter divider, then phase rotation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      q_q <= irq_ctrl_pkg::q1;
    end else begin
      div_q <= step ? 8'h00 : div_q + 8'h01;
      if (step) q_q <= irq_ctrl_pkg::subcycle_t'(q_q + 2'h1);
    end
  end
  assign ph.q1_en = step && (q_q == irq_ctrl_pkg::q1);
  assign ph.q2_en = step && (q_q == irq_ctrl_pkg::q2);
  assign ph.q4_en = step && (q_q == irq_ctrl_pkg::q4);
endmodule : phase_gen
`default_nettype wire

/* File: bench/core_model.sv */
// behavioural core sequencer and event sources facing the interrupt block
`default_nettype none
module core_model (
  // clock
  input wire logic core_clk,
  // core sequencer
  output logic sleep_instr,
  output logic return_from_irq_instr,
  output logic global_clear_instr,
  output logic [12:0] return_pc,
  // event sources
  output logic external_irq_pin,
  output logic [5:0] port_pins,
  output logic timer0_rollover,
  output logic [7:0] periph_events
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet core, fixed return address; other context is the software's job
  initial begin
    {sleep_instr, return_from_irq_instr, global_clear_instr} = 3'h0;
    return_pc = 13'h0123;
    {external_irq_pin, port_pins, timer0_rollover, periph_events} = 16'h0000;
  end
  // one-cycle instruction pulses {sleep, return, global clear}
  task automatic pulse_core(input logic [2:0] op);
    @(posedge core_clk);
    {sleep_instr, return_from_irq_instr, global_clear_instr} <= op;
    @(posedge core_clk);
    {sleep_instr, return_from_irq_instr, global_clear_instr} <= 3'h0;
  endtask : pulse_core
  // one-cycle event pulses from timer0 and the peripherals
  task automatic pulse_events(input logic t0, input logic [7:0] pe);
    @(posedge core_clk);
    timer0_rollover <= t0;
    periph_events <= pe;
    @(posedge core_clk);
    timer0_rollover <= 1'h0;
    periph_events <= 8'h00;
  endtask : pulse_events
  // pin levels hold until changed again
  task automatic set_pins(input logic ext, input logic [5:0] pp);
    @(posedge core_clk);
    external_irq_pin <= ext;
    port_pins <= pp;
  endtask : set_pins
endmodule : core_model
`default_nettype wire

/* File: bench/mcu_interrupt_controller_bench.sv */
// self-checking bench of the interrupt block over apb
`include "irq_ctrl_defines.svh"
`default_nettype none
module mcu_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_MAIN = {2'h0, `IDX_CONTROL_MAIN, 2'h0};
  localparam logic [11:0] A_PFLG = {2'h0, `IDX_PERIPH_FLAGS, 2'h0};
  localparam logic [11:0] A_PEN = {2'h0, `IDX_PERIPH_ENABLES, 2'h0};
  localparam logic [11:0] A_OPT = {2'h0, `IDX_OPTION, 2'h0};
  localparam logic [11:0] A_CSEL = {2'h0, `IDX_CHANGE_SELECT, 2'h0};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic pready, pslverr, e, ext_pin, tmr, slp, ret, gclr;
  logic [5:0] pp;
  logic [7:0] pev;
  logic [12:0] rpc, vector_pc, stack_data;
  logic irq_take, push_stack, dummy_cycle, wake_up, in_sleep;
  int miscompares = 0, total_checks = 0, takes_n = 0, wakes_n = 0, dummy_n = 0;
  always #4 core_clk = ~core_clk;
  core_model u_core (.core_clk(core_clk), .sleep_instr(slp), .return_from_irq_instr(ret),
    .global_clear_instr(gclr), .return_pc(rpc), .external_irq_pin(ext_pin),
    .port_pins(pp), .timer0_rollover(tmr), .periph_events(pev));
  irq_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_irq_pin(ext_pin), .port_pins(pp), .timer0_rollover(tmr),
    .periph_events(pev), .sleep_instr(slp), .return_from_irq_instr(ret),
    .global_clear_instr(gclr), .return_pc(rpc), .irq_take(irq_take), .vector_pc(vector_pc),
    .push_stack(push_stack), .stack_data(stack_data), .dummy_cycle(dummy_cycle),
    .wake_up(wake_up), .in_sleep(in_sleep));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // one apb transfer; an idle edge first keeps two requests from colliding
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, v, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, v, e);
    chk(v, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  // every vectoring is checked where it stands
  always @(posedge core_clk) begin
    if (irq_take === 1'b1) begin
      takes_n++;
      chk(32'(vector_pc), 32'(`VECTOR_ADDR));
      chk(32'(stack_data), 32'(rpc));
      chk(32'(push_stack), 32'h1);
    end
    if (wake_up === 1'b1) wakes_n++;
    if (dummy_cycle === 1'b1) dummy_n++;
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    idle(20000);
    miscompares++;
    complete_run();
  end
  initial begin
    idle(8);
    rst_n <= 1'b1;
    rd(A_MAIN, 32'h00);
    rd(A_PFLG, 32'h00);
    rd(A_PEN, 32'h00);
    rd(A_OPT, 32'hff);
    xfer(1'b0, 12'hffc, 32'h0, v, e);
    chk(32'(e), 32'h1);
    // events land with every enable off; bit 1 of peripheral flags stays 0
    u_core.pulse_events(1'b1, 8'hff);
    idle(8);
    rd(A_MAIN, 32'h04);
    rd(A_PFLG, 32'(`PERIPH_IMPL_MASK));
    wr(A_PEN, 32'hfd);
    rd(A_PEN, 32'hfd);
    wr(A_MAIN, 32'h84);
    idle(16);
    chk(takes_n, 0);
    wr(A_MAIN, 32'hc4);
    idle(16);
    chk(takes_n, 1);
    rd(A_MAIN, 32'h44);
    // flags cleared before returning, so no second request
    wr(A_PFLG, 32'h00);
    wr(A_MAIN, 32'h40);
    u_core.pulse_core(3'b010);
    rd(A_MAIN, 32'hc0);
    idle(16);
    chk(takes_n, 1);
    // sleep with an enabled pending flag but global enable clear
    wr(A_MAIN, 32'h40);
    u_core.pulse_events(1'b0, 8'h80);
    u_core.pulse_core(3'b100);
    idle(12);
    chk(wakes_n, 1);
    chk(takes_n, 1);
    wr(A_PFLG, 32'h00);
    // rising edge selected after reset
    u_core.set_pins(1'b1, 6'h00);
    idle(12);
    rd(A_MAIN, 32'h42);
    wr(A_OPT, 32'hbf);
    wr(A_MAIN, 32'h40);
    u_core.set_pins(1'b0, 6'h00);
    idle(12);
    rd(A_MAIN, 32'h42);
    wr(A_MAIN, 32'hd0);
    u_core.set_pins(1'b1, 6'h00);
    idle(12);
    chk(takes_n, 1);
    u_core.set_pins(1'b0, 6'h00);
    idle(20);
    chk(takes_n, 2);
    // only selected port pins count as changes
    wr(A_MAIN, 32'h40);
    wr(A_CSEL, 32'h01);
    u_core.set_pins(1'b0, 6'h02);
    idle(12);
    rd(A_MAIN, 32'h40);
    u_core.set_pins(1'b0, 6'h03);
    idle(12);
    rd(A_MAIN, 32'h41);
    // two instruction cycles of four clocks per vectoring
    chk(dummy_n, 16);
    // sleep with nothing pending, then a peripheral event wakes
    wr(A_MAIN, 32'h40);
    u_core.pulse_core(3'b100);
    idle(4);
    chk(32'(in_sleep), 32'h1);
    u_core.pulse_events(1'b0, 8'h80);
    idle(4);
    chk(32'(in_sleep), 32'h0);
    chk(wakes_n, 2);
    chk(takes_n, 2);
    complete_run();
  end
endmodule : mcu_interrupt_controller_bench
`default_nettype wire
